/* File: caeg_alert_gate.sv */
// alert-enable gating: enable words, latched flags, shared alert line
// assumes condition inputs come from same-clock logic; the alert pin is open drain
`timescale 1ns/1ps
`default_nettype none

// Operation
// - input current above high limit with bit 5 set latches flag, asserts alert.
// - battery current below low limit with bit 4 set latches flag, asserts alert.
// - die temperature above high limit with bit 3 set latches flag, asserts alert.
// - series resistance above high limit with bit 2 set latches flag, asserts alert.
// - thermistor reading above high limit with bit 1 set latches flag, alerts.
// - thermistor reading below low limit with bit 0 set latches flag, alerts.
// - charger state enable word at 0x0e, bits 12:0, cleared at reset.
// - bit 12 set: detection failure flags and alerts.
// - bit 11 set: entering battery detection flags and alerts.
// - bit 10 set: start of equalize flags and alerts.
// - bit 9 set: start of absorb flags and alerts.
// - bit 8 set: host-requested suspend flags and alerts.
// - bit 6 set: onset of constant current/voltage flags and alerts.
// - limit enable word at 0x0d, read/write, cleared at reset.
// - flags readable; host clears a flag by writing 0 to its flag location.
// - bits 1 and 0 enable missing and shorted battery alerts.
module caeg_alert_gate (
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_cmd,
	input wire logic [caeg_pkg::DATA_W-1:0] reg_wdata,
	output logic [caeg_pkg::DATA_W-1:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic input_current_high,
	input wire logic battery_current_low,
	input wire logic chip_heat_high,
	input wire logic series_resistance_high,
	input wire logic ntc_reading_high,
	input wire logic ntc_reading_low,
	input wire logic detect_failed_state,
	input wire logic detection_state,
	input wire logic equalize_state,
	input wire logic absorb_state,
	input wire logic suspended_state,
	input wire logic constant_phase_state,
	input wire logic missing_state,
	input wire logic shorted_state,
	output logic smbalert_out,
	output logic smbalert_oe
);
	import caeg_pkg::*;

	caeg_state_type q, d;
	logic [LIM_W-1:0] lim_cond;
	logic [STATE_W-1:0] state_in;
	logic [LIM_W-1:0] lim_hit;
	logic [STATE_W-1:0] state_hit;

	// =========================================
	// condition vectors
	assign lim_cond = {input_current_high, battery_current_low, chip_heat_high,
		series_resistance_high, ntc_reading_high, ntc_reading_low};
	// unused positions tied low so they can never flag
	assign state_in = {detect_failed_state, detection_state, equalize_state, absorb_state,
		suspended_state, 1'b0, constant_phase_state, 4'h0, missing_state, shorted_state};
	// limits are level conditions, states flag on entry only
	assign lim_hit = lim_cond & q.lim_en;
	assign state_hit = state_in & ~q.state_prev & q.state_en;

	// =========================================
	// next state
	always_comb begin
		d = q;
		d.state_prev = state_in;
		d.rvalid = 1'b0;
		if (reg_wr) begin
			case (reg_cmd)
				CMD_LIMIT_ENABLE: d.lim_en = reg_wdata[LIM_W-1:0];
				CMD_STATE_ENABLE: d.state_en = reg_wdata[STATE_W-1:0] & STATE_DEFINED_MASK;
				CMD_LIMIT_FLAGS: d.lim_flag = q.lim_flag & reg_wdata[LIM_W-1:0];
				CMD_STATE_FLAGS: d.state_flag = q.state_flag & reg_wdata[STATE_W-1:0];
				default: d.rvalid = 1'b0;
			endcase
		end
		// set after clear so an event in the clearing cycle survives
		d.lim_flag = d.lim_flag | lim_hit;
		d.state_flag = d.state_flag | state_hit;
		// disabling an enable withdraws its flag from the alert
		d.alert = (|(d.lim_flag & d.lim_en)) | (|(d.state_flag & d.state_en));
		if (reg_rd) begin
			d.rvalid = 1'b1;
			case (reg_cmd)
				CMD_LIMIT_ENABLE: d.rdata = {{(DATA_W-LIM_W){1'b0}}, q.lim_en};
				CMD_STATE_ENABLE: d.rdata = {{(DATA_W-STATE_W){1'b0}}, q.state_en};
				CMD_LIMIT_FLAGS: d.rdata = {{(DATA_W-LIM_W){1'b0}}, q.lim_flag};
				CMD_STATE_FLAGS: d.rdata = {{(DATA_W-STATE_W){1'b0}}, q.state_flag};
				default: d.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q.lim_en <= LIM_RESET;
			q.state_en <= STATE_RESET;
			q.lim_flag <= LIM_RESET;
			q.state_flag <= STATE_RESET;
			q.state_prev <= STATE_RESET;
			q.rdata <= 16'h0000;
			q.rvalid <= 1'b0;
			q.alert <= 1'b0;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata = q.rdata;
	assign reg_rvalid = q.rvalid;
	// open drain: only ever pulls low
	assign smbalert_out = 1'b0;
	assign smbalert_oe = q.alert;

	// =========================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// limit conditions: flag one cycle after the condition is seen; alert checked too, except for the two thermistor limits
	AST_IIN_HIGH: assert property (
		input_current_high && q.lim_en[INPUT_CURRENT_HIGH_ENABLE]
		|=> q.lim_flag[INPUT_CURRENT_HIGH_ENABLE] && smbalert_oe)
		else $error("input current high not flagged");
	AST_IBAT_LOW: assert property (
		battery_current_low && q.lim_en[BATTERY_CURRENT_LOW_ENABLE]
		|=> q.lim_flag[BATTERY_CURRENT_LOW_ENABLE] && smbalert_oe)
		else $error("battery current low not flagged");
	AST_HEAT_HIGH: assert property (
		chip_heat_high && q.lim_en[CHIP_HEAT_HIGH_ENABLE]
		|=> q.lim_flag[CHIP_HEAT_HIGH_ENABLE] && smbalert_oe)
		else $error("die temperature high not flagged");
	AST_BSR_HIGH: assert property (
		series_resistance_high && q.lim_en[SERIES_RESISTANCE_HIGH_ENABLE]
		|=> q.lim_flag[SERIES_RESISTANCE_HIGH_ENABLE] && smbalert_oe)
		else $error("series resistance high not flagged");
	AST_NTC_HIGH: assert property (
		ntc_reading_high && q.lim_en[NTC_READING_HIGH_ENABLE]
		|=> q.lim_flag[NTC_READING_HIGH_ENABLE])
		else $error("thermistor high not flagged");
	AST_NTC_LOW: assert property (
		ntc_reading_low && q.lim_en[NTC_READING_LOW_ENABLE]
		|=> q.lim_flag[NTC_READING_LOW_ENABLE])
		else $error("thermistor low not flagged");
	AST_NO_FLAG_DISABLED: assert property (
		!q.lim_en[INPUT_CURRENT_HIGH_ENABLE] && !q.lim_flag[INPUT_CURRENT_HIGH_ENABLE]
		|=> !q.lim_flag[INPUT_CURRENT_HIGH_ENABLE])
		else $error("flag set while disabled");
	AST_FLAG_HOLD: assert property (
		q.lim_flag[INPUT_CURRENT_HIGH_ENABLE] && !(reg_wr && reg_cmd == CMD_LIMIT_FLAGS)
		|=> q.lim_flag[INPUT_CURRENT_HIGH_ENABLE])
		else $error("flag lost without a clear");
	// checked while reset is active, so the default disable is lifted here
	AST_STATE_RESET: assert property (@(posedge clk) disable iff (1'b0)
		rst |=> q.state_en == STATE_RESET && q.lim_en == LIM_RESET && !smbalert_oe)
		else $error("enable words not cleared by reset");
	// state inputs flag on entry only
	AST_DETECT_FAIL: assert property (
		$rose(detect_failed_state) && q.state_en[DETECT_FAILED_ENABLE]
		|-> ##1 q.state_flag[DETECT_FAILED_ENABLE] ##0 smbalert_oe)
		else $error("detection failure not flagged");
	AST_DETECTION: assert property (
		$rose(detection_state) && q.state_en[DETECTION_ENABLE]
		|=> q.state_flag[DETECTION_ENABLE])
		else $error("detection entry not flagged");
	AST_EQUALIZE: assert property (
		$rose(equalize_state) && q.state_en[EQUALIZE_ENABLE]
		|=> q.state_flag[EQUALIZE_ENABLE])
		else $error("equalize start not flagged");
	AST_ABSORB: assert property (
		$rose(absorb_state) && q.state_en[ABSORB_ENABLE]
		|=> q.state_flag[ABSORB_ENABLE])
		else $error("absorb start not flagged");
	AST_STATE_REFUSED: assert property (
		$rose(absorb_state) && !q.state_en[ABSORB_ENABLE] && !q.state_flag[ABSORB_ENABLE]
		|=> !q.state_flag[ABSORB_ENABLE])
		else $error("absorb flagged while disabled");
	AST_SUSPEND: assert property (
		$rose(suspended_state) && q.state_en[SUSPENDED_ENABLE]
		|=> q.state_flag[SUSPENDED_ENABLE])
		else $error("suspend not flagged");
	AST_CONST_PHASE: assert property (
		$rose(constant_phase_state) && q.state_en[CONSTANT_PHASE_ENABLE]
		|=> q.state_flag[CONSTANT_PHASE_ENABLE])
		else $error("constant phase onset not flagged");
	AST_MISSING: assert property (
		$rose(missing_state) && q.state_en[MISSING_ENABLE]
		|=> q.state_flag[MISSING_ENABLE])
		else $error("missing battery not flagged");
	AST_SHORTED: assert property (
		$rose(shorted_state) && q.state_en[SHORTED_ENABLE]
		|=> q.state_flag[SHORTED_ENABLE] && smbalert_oe)
		else $error("shorted battery not flagged");
	// register port
	AST_LIM_WRITE: assert property (
		reg_wr && reg_cmd == CMD_LIMIT_ENABLE
		|=> q.lim_en == LIM_W'($past(reg_wdata)))
		else $error("limit enable write lost");
	AST_FLAG_CLEAR: assert property (
		reg_wr && reg_cmd == CMD_LIMIT_FLAGS && reg_wdata == 16'h0000 && lim_hit == 6'h00
		|=> q.lim_flag == 6'h00)
		else $error("flag not cleared");
	AST_READ_ANSWER: assert property (
		reg_rd
		|=> reg_rvalid)
		else $error("read not answered");
	AST_ALERT_GATE: assert property (
		smbalert_oe == ((|(q.lim_flag & q.lim_en))
		|| (|(q.state_flag & q.state_en))))
		else $error("alert does not match enabled flags");
	AST_RESERVED: assert property (
		reg_rd && reg_cmd == CMD_STATE_ENABLE
		|=> reg_rvalid && reg_rdata[15:13] == 3'h0 && reg_rdata[7] == 1'b0
		&& reg_rdata[5:2] == 4'h0)
		else $error("reserved bits not zero");

	COV_LIMIT_ALERT: cover property (input_current_high ##1 smbalert_oe);
	COV_STATE_ALERT: cover property ($rose(absorb_state) ##1 smbalert_oe);
	COV_CLEAR_RELEASE: cover property (smbalert_oe ##1 reg_wr ##1 !smbalert_oe);
	COV_FLAG_READ: cover property (reg_rd && reg_cmd == CMD_STATE_FLAGS ##1 reg_rvalid);
	COV_TWO_FLAGS: cover property (q.lim_flag == 6'h30 && smbalert_oe);
endmodule // caeg_alert_gate

`default_nettype wire

/* File: caeg_pkg.sv */
// constants for the charger alert-enable gating block
// assumes a command-code register port driven by the host interface logic
package caeg_pkg;
	// =========================================
	// command codes
	localparam logic [7:0] CMD_LIMIT_ENABLE = 8'h0d;
	localparam logic [7:0] CMD_STATE_ENABLE = 8'h0e;
	localparam logic [7:0] CMD_LIMIT_FLAGS = 8'h44;
	localparam logic [7:0] CMD_STATE_FLAGS = 8'h45;
	localparam int DATA_W = 16;
	localparam int LIM_W = 6;
	localparam int STATE_W = 13;
	// =========================================
	// limit word bit positions
	localparam int INPUT_CURRENT_HIGH_ENABLE = 5;
	localparam int BATTERY_CURRENT_LOW_ENABLE = 4;
	localparam int CHIP_HEAT_HIGH_ENABLE = 3;
	localparam int SERIES_RESISTANCE_HIGH_ENABLE = 2;
	localparam int NTC_READING_HIGH_ENABLE = 1;
	localparam int NTC_READING_LOW_ENABLE = 0;
	// =========================================
	// charger state word bit positions
	localparam int DETECT_FAILED_ENABLE = 12;
	localparam int DETECTION_ENABLE = 11;
	localparam int EQUALIZE_ENABLE = 10;
	localparam int ABSORB_ENABLE = 9;
	localparam int SUSPENDED_ENABLE = 8;
	localparam int CONSTANT_PHASE_ENABLE = 6;
	localparam int MISSING_ENABLE = 1;
	localparam int SHORTED_ENABLE = 0;
	localparam logic [STATE_W-1:0] STATE_DEFINED_MASK = 13'h1f43;
	localparam logic [LIM_W-1:0] LIM_RESET = 6'h00;
	localparam logic [STATE_W-1:0] STATE_RESET = 13'h0000;
	typedef struct packed {
		logic [LIM_W-1:0] lim_en;
		logic [STATE_W-1:0] state_en;
		logic [LIM_W-1:0] lim_flag;
		logic [STATE_W-1:0] state_flag;
		logic [STATE_W-1:0] state_prev;
		logic [DATA_W-1:0] rdata;
		logic rvalid;
		logic alert;
	} caeg_state_type;
endpackage

/* File: caeg_host_model.sv */
// host-side model: register strobes and the open-drain alert line level
// assumes a posedge-sampling device; strobes move only on the falling edge
`timescale 1ns/1ps
`default_nettype none
module caeg_host_model (
	input wire logic clk,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_cmd,
	output logic [caeg_pkg::DATA_W-1:0] reg_wdata,
	input wire logic smbalert_out,
	input wire logic smbalert_oe,
	output logic alert_n
);
	import caeg_pkg::*;
	// pull-up holds the line high unless the device pulls it
	assign alert_n = smbalert_oe ? smbalert_out : 1'b1;
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_cmd = 8'h00;
		reg_wdata = 16'h0000;
	end
	// one access; flag clears travel through the same write path
	task automatic acc(input logic w, input logic [7:0] c, input logic [DATA_W-1:0] d);
		@(negedge clk);
		reg_wr = w;
		reg_rd = !w;
		reg_cmd = c;
		reg_wdata = d;
		@(posedge clk);
		@(negedge clk);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		// released bus must not keep showing the old value
		reg_cmd = ~c;
		reg_wdata = ~d;
	endtask
endmodule // caeg_host_model
`default_nettype wire

/* File: charger_alert_enable_gating_tb.sv */
// self-checking bench for the alert-enable gating block
// assumes the host model drives the register port; reads are checked from a queue
`timescale 1ns/1ps
`default_nettype none
module charger_alert_enable_gating_tb;
	import caeg_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [5:0] lim_c = 6'h00;
	logic [12:0] st_c = 13'h0000;
	logic reg_wr, reg_rd, reg_rvalid, smbalert_out, smbalert_oe, alert_n;
	logic [7:0] reg_cmd, cmd_en, cmd_fl;
	logic [15:0] reg_wdata, reg_rdata, m;
	logic [15:0] exp_q[$];
	logic [31:0] seed = 32'hc0dc2c3b;
	int bad_count = 0;
	int checks_done = 0;
	int bits[14] = '{5, 4, 3, 2, 1, 0, 12, 11, 10, 9, 8, 6, 1, 0};
	always #5 clk = ~clk;
	caeg_alert_gate DUT (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_cmd(reg_cmd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.input_current_high(lim_c[5]), .battery_current_low(lim_c[4]), .chip_heat_high(lim_c[3]),
		.series_resistance_high(lim_c[2]), .ntc_reading_high(lim_c[1]), .ntc_reading_low(lim_c[0]),
		.detect_failed_state(st_c[12]), .detection_state(st_c[11]), .equalize_state(st_c[10]),
		.absorb_state(st_c[9]), .suspended_state(st_c[8]), .constant_phase_state(st_c[6]),
		.missing_state(st_c[1]), .shorted_state(st_c[0]), .smbalert_out(smbalert_out),
		.smbalert_oe(smbalert_oe));
	caeg_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_cmd(reg_cmd),
		.reg_wdata(reg_wdata), .smbalert_out(smbalert_out), .smbalert_oe(smbalert_oe),
		.alert_n(alert_n));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	task automatic rd(input logic [7:0] c, input logic [15:0] e);
		exp_q.push_back(e);
		host.acc(1'b0, c, 16'h0000);
	endtask
	task automatic pulse(input logic [5:0] l, input logic [12:0] s);
		@(negedge clk);
		lim_c = l;
		st_c = s;
		@(negedge clk);
		lim_c = 6'h00;
		st_c = 13'h0000;
	endtask
	task automatic results();
		if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// =========================================
	// read monitor: oldest note against each answer
	always @(negedge clk) begin
		if (reg_rvalid === 1'b1) begin
			if (exp_q.size() == 0) check(1'b0, "unrequested read answer");
			else check(reg_rdata === exp_q.pop_front(), "read data");
		end
	end
	// =========================================
	// main sequence
	initial begin
		repeat (3) @(negedge clk);
		rst = 1'b0;
		check(alert_n === 1'b1, "alert after reset");
		rd(CMD_LIMIT_ENABLE, 16'h0000);
		rd(CMD_STATE_ENABLE, 16'h0000);
		rd(CMD_STATE_FLAGS, 16'h0000);
		rd(8'h7f, 16'h0000);
		for (int k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			host.acc(1'b1, CMD_LIMIT_ENABLE, seed[15:0]);
			rd(CMD_LIMIT_ENABLE, {10'h000, seed[5:0]});
			host.acc(1'b1, CMD_STATE_ENABLE, seed[31:16]);
			rd(CMD_STATE_ENABLE, {3'h0, seed[28:16] & STATE_DEFINED_MASK});
		end
		// each event: refused while disabled, then latched, alerted and cleared
		for (int j = 0; j < 14; j++) begin
			cmd_en = (j < 6) ? CMD_LIMIT_ENABLE : CMD_STATE_ENABLE;
			cmd_fl = (j < 6) ? CMD_LIMIT_FLAGS : CMD_STATE_FLAGS;
			m = 16'h0001 << bits[j];
			host.acc(1'b1, cmd_en, 16'h0000);
			pulse((j < 6) ? m[5:0] : 6'h00, (j < 6) ? 13'h0000 : m[12:0]);
			check(alert_n === 1'b1, "disabled event alerted");
			rd(cmd_fl, 16'h0000);
			host.acc(1'b1, cmd_en, m);
			pulse((j < 6) ? m[5:0] : 6'h00, (j < 6) ? 13'h0000 : m[12:0]);
			check(alert_n === 1'b0, "enabled event silent");
			rd(cmd_fl, m);
			host.acc(1'b1, cmd_fl, 16'h0000);
			check(alert_n === 1'b1, "alert kept after clear");
		end
		// two flags: alert stays until the last one is cleared
		host.acc(1'b1, CMD_LIMIT_ENABLE, 16'h0030);
		pulse(6'h30, 13'h0000);
		host.acc(1'b1, CMD_LIMIT_FLAGS, 16'h0010);
		check(alert_n === 1'b0, "alert dropped early");
		rd(CMD_LIMIT_FLAGS, 16'h0010);
		host.acc(1'b1, CMD_LIMIT_FLAGS, 16'h0000);
		check(alert_n === 1'b1, "alert not released");
		// set wins over a clear in the same cycle; a withdrawn enable keeps its flag
		host.acc(1'b1, CMD_LIMIT_ENABLE, 16'h0020);
		@(negedge clk);
		lim_c = 6'h20;
		host.acc(1'b1, CMD_LIMIT_FLAGS, 16'h0000);
		lim_c = 6'h00;
		rd(CMD_LIMIT_FLAGS, 16'h0020);
		host.acc(1'b1, CMD_LIMIT_ENABLE, 16'h0000);
		check(alert_n === 1'b1, "alert kept after enable withdrawn");
		rd(CMD_LIMIT_FLAGS, 16'h0020);
		// unknown codes are ignored; a mid-run reset clears the state enable, flags and alert
		host.acc(1'b1, CMD_STATE_ENABLE, 16'h0200);
		pulse(6'h00, 13'h0200);
		host.acc(1'b1, 8'h7f, 16'h0000);
		rd(CMD_STATE_ENABLE, 16'h0200);
		check(alert_n === 1'b0, "absorb entry silent");
		@(negedge clk);
		rst = 1'b1;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		check(alert_n === 1'b1, "alert after mid-run reset");
		rd(CMD_STATE_ENABLE, 16'h0000);
		rd(CMD_LIMIT_FLAGS, 16'h0000);
		rd(CMD_STATE_FLAGS, 16'h0000);
		for (int t = 0; t < 20 && exp_q.size() > 0; t++) @(negedge clk);
		if (exp_q.size() > 0) check(1'b0, "reads unanswered");
		results();
	end
	initial begin
		#200000;
		check(1'b0, "run timed out");
		results();
	end
endmodule // charger_alert_enable_gating_tb
`default_nettype wire
